/* File: hdl/fsiu_consts.svh */
`ifndef FSIU_CONSTS_SVH
`define FSIU_CONSTS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define FSIU_IDX_ENABLE     8'h2F
`define FSIU_IDX_REQUEST    8'h30
`define FSIU_IDX_STATUS     8'h31

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define FSIU_ENABLE_RESET   4'h0
`define FSIU_REQUEST_RESET  4'h0
`define FSIU_SP_RESET       3'h0

// ----------------------------------------------------------------------
// source bit positions in enable and request registers
// ----------------------------------------------------------------------
`define FSIU_SRC_SERIAL     0
`define FSIU_SRC_BTIMER1    1
`define FSIU_SRC_TIMER12    2
`define FSIU_SRC_EXTPIN     3

// ----------------------------------------------------------------------
// vector addresses per source
// ----------------------------------------------------------------------
`define FSIU_VEC_EXTPIN     3'h4
`define FSIU_VEC_TIMER12    3'h3
`define FSIU_VEC_BTIMER1    3'h2
`define FSIU_VEC_SERIAL     3'h1
`define FSIU_VEC_NONE       3'h0

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define FSIU_ST_GATE        0
`define FSIU_ST_EIPEND      1
`define FSIU_ST_DEPTH_LSB   2
`define FSIU_ST_SP_LSB      4
`define FSIU_ST_VEC_LSB     8
`define FSIU_ST_INTCYC      12

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define FSIU_INSTR_TIME_US  4.44
`define FSIU_CLK_MHZ        50
`define FSIU_ISTK_DEPTH     2

`endif

/* File: hdl/fsiu_pkg.sv */
package fsiu_pkg;

  // saved system register set
  typedef struct packed {
    logic [1:0] bank;
    logic [4:0] regPtr;
    logic [4:0] statusWord;
  } fsiu_sys_s;

  // instruction events from the sequencer, valid with strobe
  typedef struct packed {
    logic strobe;
    logic enableInstr;
    logic maskInstr;
    logic returnInstr;
    logic tableFirst;
    logic skipNop;
    logic clockStop;
  } fsiu_instr_s;

  typedef enum logic {FSIU_RUN, FSIU_INTCYC} fsiu_state_e;

  typedef logic [11:0] fsiu_pc_t;
  typedef logic [2:0]  fsiu_vec_t;
  typedef logic [2:0]  fsiu_sp_t;

endpackage

/* File: hdl/fsiu_core.sv */
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "fsiu_consts.svh"

// Notes on behaviour
// RL1: ack needs enable, request and gate
// RL2: four enable bits, cleared by resets
// RL3: fixed vector per source on ack
// RL4: ack pushes system registers, then clears them
// RL5: save stack holds two levels
// RL6: third push discards the oldest entry
// RL7: return pops newest entry into system registers
// RL8: ack decrements pointer, stores program counter
// RL9: return loads counter, then increments pointer
// RL10: enable delayed one cycle, mask immediate
// RL11: any ack clears the gate
// RL12: redundant enable or mask changes nothing
// RL13: gate cleared by all three resets
// RL14: peripheral request sets sticky request flag
// RL15: ack clears winner flag, outputs vector
// RL16: fixed priority, pin, timer, btimer, serial
// RL17: disabled source never acknowledged
// RL18: ack deferred over table read, skipped nop
// RL19: ack takes one dedicated instruction time
// RL20: source pending when request and enable set
// RL21: flag stays until ack or software clear
// RL22: entry holds bank 2, pointer 5, status 5
// RL23: two-entry lifo, overflow drops oldest
module fsiu_core
  import fsiu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  srcRequest,
  output logic      [3:0]  srcAck,
  input  wire fsiu_instr_s cpuInstr,
  input  wire fsiu_pc_t    cpuPc,
  input  wire fsiu_sys_s   cpuSys,
  input  wire logic        ceReset,
  output logic             intCycle,
  output fsiu_vec_t        vectorOut,
  output logic             pcLoad,
  output fsiu_pc_t         pcLoadValue,
  output logic             sysLoad,
  output fsiu_sys_s        sysLoadValue
);

  // ----------------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------------
  localparam int IntCycLen =
    int'(`FSIU_INSTR_TIME_US * `FSIU_CLK_MHZ);
  localparam logic [7:0] IntCycLast = 8'(IntCycLen - 1);
  localparam int AstkDepth = 8;

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  // fixed priority pick, one-hot result
  function automatic logic [3:0] prioPick(input logic [3:0] pend);
    logic [3:0] pick;
    pick = 4'h0;
    if (pend[`FSIU_SRC_EXTPIN]) begin
      pick[`FSIU_SRC_EXTPIN] = 1'b1;
    end else if (pend[`FSIU_SRC_TIMER12]) begin
      pick[`FSIU_SRC_TIMER12] = 1'b1;
    end else if (pend[`FSIU_SRC_BTIMER1]) begin
      pick[`FSIU_SRC_BTIMER1] = 1'b1;
    end else if (pend[`FSIU_SRC_SERIAL]) begin
      pick[`FSIU_SRC_SERIAL] = 1'b1;
    end
    return pick;
  endfunction

  // vector of a one-hot source
  function automatic fsiu_vec_t vecOf(input logic [3:0] oneHot);
    fsiu_vec_t v;
    v = `FSIU_VEC_NONE;
    if (oneHot[`FSIU_SRC_EXTPIN]) begin
      v = `FSIU_VEC_EXTPIN;
    end else if (oneHot[`FSIU_SRC_TIMER12]) begin
      v = `FSIU_VEC_TIMER12;
    end else if (oneHot[`FSIU_SRC_BTIMER1]) begin
      v = `FSIU_VEC_BTIMER1;
    end else if (oneHot[`FSIU_SRC_SERIAL]) begin
      v = `FSIU_VEC_SERIAL;
    end
    return v;
  endfunction

  // byte address of a register index
  function automatic logic [9:0] byteAddr(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [3:0]  enable_ff;
  logic [3:0]  request_ff;
  logic        gate_ff;
  logic        eiPend_ff;
  fsiu_state_e state_ff;
  logic [7:0]  cycCnt_ff;
  fsiu_sp_t    sp_ff;
  fsiu_pc_t    astk_ff [AstkDepth];
  fsiu_sys_s   istk_ff [`FSIU_ISTK_DEPTH];
  logic [1:0]  depth_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [3:0]  srcAck_ff;
  logic        intCycle_ff;
  fsiu_vec_t   vector_ff;
  logic        pcLoad_ff;
  fsiu_pc_t    pcLoadValue_ff;
  logic        sysLoad_ff;
  fsiu_sys_s   sysLoadValue_ff;

  // ----------------------------------------------------------------------
  // decode of instruction events and acknowledge
  // ----------------------------------------------------------------------
  logic       instrStep;
  logic       clearAll;
  logic       holdOff;
  logic [3:0] pending;
  logic [3:0] winner;
  logic       ackNow;
  logic       retNow;
  fsiu_sp_t   spDec;

  // strobes are ignored while the interrupt cycle runs
  assign instrStep = cpuInstr.strobe && (state_ff == FSIU_RUN);
  assign clearAll  = ceReset || (instrStep && cpuInstr.clockStop);
  // RL18: defer over table read
  assign holdOff   = cpuInstr.tableFirst || cpuInstr.skipNop;
  // RL20: per-source pending output
  assign pending   = request_ff & enable_ff;
  // RL16: fixed priority pick
  // RL17: disabled source masked
  assign winner    = prioPick(pending);
  // RL1: three conditions combined
  assign ackNow    = instrStep && gate_ff && (|pending) && !holdOff &&
                     !cpuInstr.maskInstr && !cpuInstr.returnInstr &&
                     !clearAll;
  assign retNow    = instrStep && cpuInstr.returnInstr && !clearAll;
  assign spDec     = sp_ff - 3'h1;

  // ----------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------
  logic apbFirst;
  logic apbDone;
  logic hitEnable;
  logic hitRequest;
  logic hitStatus;

  assign apbFirst   = psel && penable && !pready_ff;
  assign apbDone    = psel && penable && pready_ff;
  assign hitEnable  = (paddr == byteAddr(`FSIU_IDX_ENABLE));
  assign hitRequest = (paddr == byteAddr(`FSIU_IDX_REQUEST));
  assign hitStatus  = (paddr == byteAddr(`FSIU_IDX_STATUS));

  // ready one cycle into the access phase
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= apbFirst;
    end
  end

  // read data and error captured in the first access cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (apbFirst) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
      if (hitEnable) begin
        prdata_ff[3:0] <= enable_ff;
      end else if (hitRequest) begin
        prdata_ff[3:0] <= request_ff;
      end else if (hitStatus) begin
        prdata_ff[`FSIU_ST_GATE]   <= gate_ff;
        prdata_ff[`FSIU_ST_EIPEND] <= eiPend_ff;
        prdata_ff[`FSIU_ST_DEPTH_LSB +: 2] <= depth_ff;
        prdata_ff[`FSIU_ST_SP_LSB +: 3]    <= sp_ff;
        prdata_ff[`FSIU_ST_VEC_LSB +: 3]   <= vector_ff;
        prdata_ff[`FSIU_ST_INTCYC] <= intCycle_ff;
      end else begin
        pslverr_ff <= 1'b1; // unmapped address
      end
    end else if (!psel) begin
      pslverr_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // source enable bits
  // ----------------------------------------------------------------------
  // RL2: enable bits and their resets
  always_ff @(posedge clk_sys) begin
    if (srst || clearAll) begin
      enable_ff <= `FSIU_ENABLE_RESET;
    end else if (apbDone && pwrite && hitEnable) begin
      enable_ff <= pwdata[3:0];
    end
  end

  // ----------------------------------------------------------------------
  // source request flags
  // ----------------------------------------------------------------------
  logic       swReqWrite;
  logic [3:0] reqSet;
  logic [3:0] reqClr;

  assign swReqWrite = apbDone && pwrite && hitRequest;
  // RL14: peripheral request sets
  // RL21: software one sets, zero clears
  assign reqSet = srcRequest | (swReqWrite ? pwdata[3:0] : 4'h0);
  // RL15: winner flag cleared on ack
  assign reqClr = (ackNow ? winner : 4'h0) |
                  (swReqWrite ? ~pwdata[3:0] : 4'h0);

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (srst || clearAll) begin
      request_ff <= `FSIU_REQUEST_RESET;
    end else begin
      request_ff <= reqSet | (request_ff & ~reqClr);
    end
  end

  // ----------------------------------------------------------------------
  // global interrupt gate
  // ----------------------------------------------------------------------
  // RL13: cleared by all resets
  // RL10: mask clears at once
  // RL11: ack clears gate
  always_ff @(posedge clk_sys) begin
    if (srst || clearAll) begin
      gate_ff <= 1'b0;
    end else if (instrStep && cpuInstr.maskInstr) begin
      gate_ff <= 1'b0;
    end else if (ackNow) begin
      gate_ff <= 1'b0;
    end else if (instrStep && eiPend_ff) begin
      gate_ff <= 1'b1;
    end
  end

  // RL10: enable waits until the next instruction strobe
  // RL12: redundant enable ignored
  always_ff @(posedge clk_sys) begin
    if (srst || clearAll) begin
      eiPend_ff <= 1'b0;
    end else if (instrStep && cpuInstr.maskInstr) begin
      eiPend_ff <= 1'b0;
    end else if (instrStep && eiPend_ff) begin
      eiPend_ff <= 1'b0;
    end else if (instrStep && cpuInstr.enableInstr && !gate_ff) begin
      eiPend_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt cycle sequencer
  // ----------------------------------------------------------------------
  // RL19: one instruction time long
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_ff    <= FSIU_RUN;
      cycCnt_ff   <= 8'h00;
      intCycle_ff <= 1'b0;
    end else begin
      case (state_ff)
        FSIU_RUN: begin
          if (ackNow) begin
            state_ff    <= FSIU_INTCYC;
            cycCnt_ff   <= IntCycLast;
            intCycle_ff <= 1'b1;
          end
        end
        FSIU_INTCYC: begin
          if (cycCnt_ff == 8'h00) begin
            state_ff    <= FSIU_RUN;
            intCycle_ff <= 1'b0;
          end else begin
            cycCnt_ff <= cycCnt_ff - 8'h01;
          end
        end
        default: begin
          state_ff    <= FSIU_RUN;
          intCycle_ff <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // acknowledge and vector outputs
  // ----------------------------------------------------------------------
  // RL3: vector of the winner
  // RL15: acknowledge to winning source
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      srcAck_ff <= 4'h0;
      vector_ff <= `FSIU_VEC_NONE;
    end else begin
      srcAck_ff <= ackNow ? winner : 4'h0;
      if (ackNow) begin
        vector_ff <= vecOf(winner);
      end
    end
  end

  // ----------------------------------------------------------------------
  // stack pointer and address stack
  // ----------------------------------------------------------------------
  // RL8: decrement then store pc
  // RL9: load pc then increment
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sp_ff <= `FSIU_SP_RESET;
      for (int i = 0; i < AstkDepth; i++) begin
        astk_ff[i] <= 12'h000;
      end
    end else if (ackNow) begin
      sp_ff          <= spDec;
      astk_ff[spDec] <= cpuPc;
    end else if (retNow) begin
      sp_ff <= sp_ff + 3'h1;
    end
  end

  // program counter load pulse, vector or return address
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pcLoad_ff      <= 1'b0;
      pcLoadValue_ff <= 12'h000;
    end else begin
      pcLoad_ff <= ackNow || retNow;
      if (ackNow) begin
        pcLoadValue_ff <= {9'h000, vecOf(winner)};
      end else if (retNow) begin
        pcLoadValue_ff <= astk_ff[sp_ff];
      end
    end
  end

  // ----------------------------------------------------------------------
  // interrupt save stack
  // ----------------------------------------------------------------------
  // RL22: entry holds bank, pointer, status
  // RL5: two levels deep
  // RL6: overflow drops oldest
  // RL23: lifo shift on push and pop
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      depth_ff <= 2'h0;
      for (int i = 0; i < `FSIU_ISTK_DEPTH; i++) begin
        istk_ff[i] <= '0;
      end
    end else if (ackNow) begin
      istk_ff[1] <= istk_ff[0];
      istk_ff[0] <= cpuSys;
      if (depth_ff != 2'h2) begin
        depth_ff <= depth_ff + 2'h1;
      end
    end else if (retNow) begin
      istk_ff[0] <= istk_ff[1];
      istk_ff[1] <= '0;
      if (depth_ff != 2'h0) begin
        depth_ff <= depth_ff - 2'h1;
      end
    end
  end

  // RL4: system registers cleared on ack
  // RL7: newest entry restored on return
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sysLoad_ff      <= 1'b0;
      sysLoadValue_ff <= '0;
    end else begin
      sysLoad_ff <= ackNow || retNow;
      if (ackNow) begin
        sysLoadValue_ff <= '0;
      end else if (retNow) begin
        sysLoadValue_ff <= (depth_ff == 2'h0) ? '0 : istk_ff[0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign prdata       = prdata_ff;
  assign pready       = pready_ff;
  assign pslverr      = pslverr_ff;
  assign srcAck       = srcAck_ff;
  assign intCycle     = intCycle_ff;
  assign vectorOut    = vector_ff;
  assign pcLoad       = pcLoad_ff;
  assign pcLoadValue  = pcLoadValue_ff;
  assign sysLoad      = sysLoad_ff;
  assign sysLoadValue = sysLoadValue_ff;

endmodule

/* File: tb/fsiu_checker.sv */
`timescale 1ns/1ps
module fsiu_checker
  import fsiu_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [3:0]  srcAck,
  input wire fsiu_instr_s cpuInstr,
  input wire logic        ceReset,
  input wire logic        intCycle,
  input wire fsiu_vec_t   vectorOut,
  input wire logic        pcLoad,
  input wire fsiu_pc_t    pcLoadValue,
  input wire logic        sysLoad,
  input wire fsiu_sys_s   sysLoadValue
);
  logic [8:0] icCnt_ff;
  logic [2:0] expVec;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  // length of the running interrupt cycle
  always_ff @(posedge clk_sys) begin
    if (srst || !intCycle) begin
      icCnt_ff <= 9'h000;
    end else begin
      icCnt_ff <= icCnt_ff + 9'h001;
    end
  end
  // vector that the granted source should produce
  assign expVec = srcAck[3] ? 3'h4 : srcAck[2] ? 3'h3 :
                  srcAck[1] ? 3'h2 : 3'h1;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  vec_match_a: assert property (
    srcAck != 4'h0 |-> vectorOut == expVec && pcLoadValue == 12'(expVec))
    else $error("vector does not match granted source");
  ack_shape_a: assert property (
    srcAck != 4'h0 |-> $onehot(srcAck) && pcLoad && sysLoad
      && $rose(intCycle)) else $error("grant not one-hot with loads");
  sys_clear_a: assert property (
    srcAck != 4'h0 |-> sysLoadValue == fsiu_sys_s'(12'h000))
    else $error("system registers not cleared on grant");
  ack_cause_a: assert property (
    srcAck != 4'h0 |-> $past(cpuInstr.strobe && !intCycle && !ceReset))
    else $error("grant without an accepted strobe");
  hold_off_a: assert property (
    cpuInstr.strobe && (cpuInstr.maskInstr || cpuInstr.tableFirst
      || cpuInstr.skipNop) |=> srcAck == 4'h0)
    else $error("grant in a held-off strobe");
  ce_block_a: assert property (
    ceReset |=> srcAck == 4'h0) else $error("grant during chip reset");
  ack_pulse_a: assert property (
    srcAck != 4'h0 |=> srcAck == 4'h0 && !pcLoad && !sysLoad)
    else $error("grant pulse too long");
  intcyc_len_a: assert property (
    $fell(intCycle) |-> icCnt_ff == 9'h0DE)
    else $error("interrupt cycle length wrong");
  ret_load_a: assert property (
    pcLoad && srcAck == 4'h0 |->
      $past(cpuInstr.strobe && cpuInstr.returnInstr) && sysLoad)
    else $error("counter load without return");
  apb_wait_a: assert property (
    psel && $rose(penable) |-> !pready ##1 pready)
    else $error("bus answer not after one wait state");
endmodule

bind fsiu_core fsiu_checker chk (.clk_sys, .srst, .psel, .penable,
  .pready, .srcAck, .cpuInstr, .ceReset, .intCycle, .vectorOut,
  .pcLoad, .pcLoadValue, .sysLoad, .sysLoadValue);

/* File: tb/fsiu_cpu_model.sv */
`timescale 1ns/1ps
module fsiu_cpu_model
  import fsiu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire fsiu_instr_s nextOp,
  input  wire logic        intCycle,
  input  wire logic        pcLoad,
  input  wire fsiu_pc_t    pcLoadValue,
  input  wire logic        sysLoad,
  input  wire fsiu_sys_s   sysLoadValue,
  output fsiu_instr_s      cpuInstr,
  output fsiu_pc_t         cpuPc,
  output fsiu_sys_s        cpuSys
);
  logic [2:0] phase_ff;
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // one instruction every eight clocks, frozen in an interrupt cycle
  always_ff @(posedge clk_sys) begin
    if (srst || intCycle) begin
      phase_ff <= 3'h0;
    end else begin
      phase_ff <= phase_ff + 3'h1;
    end
  end
  // strobe carries the instruction queued by the bench
  always_ff @(posedge clk_sys) begin
    cpuInstr <= '0;
    if (!srst && !intCycle && phase_ff == 3'h7) begin
      cpuInstr <= nextOp;
      cpuInstr.strobe <= 1'b1;
    end
  end
  // counter and system registers follow loads, else step
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cpuPc  <= 12'h100;
      cpuSys <= '0;
    end else begin
      if (pcLoad) begin
        cpuPc <= pcLoadValue;
      end else if (cpuInstr.strobe) begin
        cpuPc <= cpuPc + 12'h001;
      end
      if (sysLoad) begin
        cpuSys <= sysLoadValue;
      end else if (cpuInstr.strobe) begin
        cpuSys <= fsiu_sys_s'(12'(cpuSys) + 12'h0A5);
      end
    end
  end
endmodule

/* File: tb/tb_four_source_interrupt_unit.sv */
`timescale 1ns/1ps
module tb_four_source_interrupt_unit
  import fsiu_pkg::*;
;
  localparam logic [9:0] ADR_EN = 10'h0BC;
  localparam logic [9:0] ADR_RQ = 10'h0C0;
  localparam logic [9:0] ADR_ST = 10'h0C4;
  logic clk_sys, srst, psel, penable, pwrite, pready, pslverr, er;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] srcRequest, srcAck;
  logic ceReset, intCycle, pcLoad, sysLoad;
  fsiu_instr_s nextOp, cpuInstr;
  fsiu_pc_t cpuPc, pcLoadValue, lastPc;
  fsiu_sys_s cpuSys, sysLoadValue, lastSys;
  fsiu_vec_t vectorOut;
  fsiu_pc_t pcQ[$];
  fsiu_sys_s sysQ[$];
  int failures, samplesChecked;

  fsiu_core dut (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .srcRequest, .srcAck,
    .cpuInstr, .cpuPc, .cpuSys, .ceReset, .intCycle, .vectorOut,
    .pcLoad, .pcLoadValue, .sysLoad, .sysLoadValue);
  fsiu_cpu_model cpu (.clk_sys, .srst, .nextOp, .intCycle, .pcLoad,
    .pcLoadValue, .sysLoad, .sysLoadValue, .cpuInstr, .cpuPc, .cpuSys);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // clock
  always #10 clk_sys = ~clk_sys;
  // remember counter and registers at every strobe
  always @(posedge clk_sys) begin
    if (cpuInstr.strobe) begin
      lastPc  <= cpuPc;
      lastSys <= cpuSys;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // ready, data and error are taken at the edge that sees ready
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [9:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd & m, e);
  endtask
  task automatic op(input logic [6:0] o);
    int n;
    @(posedge clk_sys);
    nextOp <= fsiu_instr_s'(o);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (cpuInstr !== fsiu_instr_s'({1'b1, o[5:0]}) && n < 600);
    chk(32'(n < 600), 32'h0000_0001);
    @(posedge clk_sys);
    nextOp <= '0;
  endtask
  task automatic no_ack();
    @(negedge clk_sys);
    chk(32'(srcAck), 32'h0000_0000);
  endtask
  task automatic wait_ack(input logic [3:0] a, input logic [2:0] v);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (srcAck === 4'h0 && n < 600);
    chk(32'(srcAck), 32'(a));
    chk(32'(pcLoadValue), 32'(v));
    chk(32'(sysLoadValue), 32'h0000_0000);
    pcQ.push_back(lastPc);
    sysQ.push_back(lastSys);
    if (sysQ.size() > 2) void'(sysQ.pop_front());
  endtask
  task automatic ret_check();
    fsiu_sys_s es;
    es = '0;
    if (sysQ.size() > 0) es = sysQ.pop_back();
    op(7'h08);
    // loads stand in the cycle after the return strobe
    @(negedge clk_sys);
    chk(32'(pcLoad), 32'h0000_0001);
    chk(32'(sysLoad), 32'h0000_0001);
    chk(32'(pcLoadValue), 32'(pcQ.pop_back()));
    chk(32'(sysLoadValue), 32'(es));
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rdc(ADR_EN, 32'h0000_000F, 32'h0000_0000);
    apb(1'b1, ADR_EN, 32'h0000_000F);
    rdc(ADR_EN, 32'h0000_000F, 32'h0000_000F);
    apb(1'b0, 10'h3FC, 32'h0000_0000);
    chk(32'(er), 32'h0000_0001);
  endtask
  task automatic t_nest();
    @(posedge clk_sys);
    srcRequest <= 4'h8;
    @(posedge clk_sys);
    srcRequest <= 4'h0;
    repeat (40) @(posedge clk_sys);
    rdc(ADR_RQ, 32'h0000_000F, 32'h0000_0008);
    op(7'h20);
    op(7'h00);
    no_ack();
    wait_ack(4'h8, 3'h4);
    rdc(ADR_RQ, 32'h0000_000F, 32'h0000_0000);
    rdc(ADR_ST, 32'h0000_0001, 32'h0000_0000);
    apb(1'b1, ADR_EN, 32'h0000_0007);
    apb(1'b1, ADR_RQ, 32'h0000_000F);
    for (int i = 2; i >= 0; i--) begin
      op(7'h20);
      wait_ack(4'(1 << i), 3'(i + 1));
    end
    for (int i = 0; i < 4; i++) begin
      ret_check();
    end
    rdc(ADR_RQ, 32'h0000_000F, 32'h0000_0008);
    apb(1'b1, ADR_RQ, 32'h0000_0000);
    rdc(ADR_RQ, 32'h0000_000F, 32'h0000_0000);
  endtask
  task automatic t_hold();
    apb(1'b1, ADR_EN, 32'h0000_0002);
    apb(1'b1, ADR_RQ, 32'h0000_0002);
    op(7'h20);
    op(7'h10);
    no_ack();
    op(7'h00);
    no_ack();
    op(7'h20);
    op(7'h20);
    op(7'h04);
    no_ack();
    wait_ack(4'h2, 3'h2);
    ret_check();
  endtask
  task automatic t_ce();
    apb(1'b1, ADR_EN, 32'h0000_000F);
    op(7'h20);
    op(7'h00);
    op(7'h20);
    rdc(ADR_ST, 32'h0000_0003, 32'h0000_0001);
    @(posedge clk_sys);
    ceReset <= 1'b1;
    @(posedge clk_sys);
    ceReset <= 1'b0;
    rdc(ADR_EN, 32'h0000_000F, 32'h0000_0000);
    rdc(ADR_ST, 32'h0000_0001, 32'h0000_0000);
    apb(1'b1, ADR_EN, 32'h0000_000F);
    op(7'h20);
    op(7'h00);
    rdc(ADR_ST, 32'h0000_0001, 32'h0000_0001);
    op(7'h01);
    rdc(ADR_EN, 32'h0000_000F, 32'h0000_0000);
    rdc(ADR_ST, 32'h0000_0001, 32'h0000_0000);
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    srst = 1'b1;
    {psel, penable, pwrite, ceReset} = 4'h0;
    paddr = '0;
    pwdata = '0;
    srcRequest = '0;
    nextOp = '0;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    t_regs();
    t_nest();
    t_hold();
    t_ce();
    give_verdict();
  end
  // cut a hang short
  initial begin
    #400000;
    failures++;
    give_verdict();
  end
endmodule
